// File: hdl/cir_pkg.sv
package cir_pkg;
  // Operation selects presented by the fetch stage
  typedef enum logic [2:0] {
    CIR_OP_NOP,
    CIR_OP_STORE_IND,
    CIR_OP_STORE_REL,
    CIR_OP_OPTION,
    CIR_OP_RESET,
    CIR_OP_RET_IRQ,
    CIR_OP_RETURN,
    CIR_OP_RET_LIT
  } cir_op_t;

  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  localparam int PTR_W = 16;
  localparam int PC_W = 15;
  localparam int STACK_DEPTH = 16;
  localparam int SP_W = 4;

  localparam int GIE_BIT = 7;
  localparam logic [7:0] INTERRUPT_CONTROL_REGISTER_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] WDATA_RESET = 8'h00;
  localparam logic SW_FLAG_RESET = 1'b1;
  localparam logic [SP_W-1:0] SP_RESET = 4'hF;
  localparam int RET_CYCLES = 2;
endpackage : cir_pkg

// File: hdl/cir_stack_if.sv
`timescale 1ns/10ps
interface cir_stack_if;
  logic push;
  logic pop;
  logic [cir_pkg::PC_W-1:0] push_data;
  logic [cir_pkg::PC_W-1:0] top;
  modport core (output push, output pop, output push_data, input top);
  modport mem (input push, input pop, input push_data, output top);
endinterface : cir_stack_if

// File: hdl/cir_stack.sv
`timescale 1ns/10ps
module cir_stack (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Core side
  cir_stack_if.mem stk
);
  logic [cir_pkg::PC_W-1:0] mem [cir_pkg::STACK_DEPTH];
  logic [cir_pkg::SP_W-1:0] sp;
  logic [cir_pkg::SP_W-1:0] next_sp;
  logic [cir_pkg::PC_W-1:0] top;
  logic [cir_pkg::PC_W-1:0] next_top;

  always_comb begin
    next_sp = sp;
    next_top = top;
    if (stk.push) begin
      next_sp = sp + 4'h1;
      next_top = stk.push_data;
    end else if (stk.pop) begin
      next_sp = sp - 4'h1;
      next_top = mem[sp - 4'h1];
    end
  end

  // Storage has no reset; the pointer and registered top do
  always_ff @(posedge ref_clk) begin
    if (stk.push) begin
      mem[sp + 4'h1] <= stk.push_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sp <= cir_pkg::SP_RESET;
      top <= cir_pkg::PC_RESET;
    end else begin
      sp <= next_sp;
      top <= next_top;
    end
  end

  assign stk.top = top;
endmodule : cir_stack

// File: hdl/cir_core.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Store mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - The indirect window is not storage; writes go to pointer address.
// - Pointer is 16 bits and wraps at both ends.
// - Pointer adjustment changes no status flag.
// - Option load copies accumulator to option register in one cycle.
// - Software reset resets all but the stack and clears the software reset flag.
// - Return from irq pops stack to PC, sets enable bit 7, two cycles.
// - Subroutine return pops stack to PC in two cycles, no flags.
// - Literal return loads accumulator from literal and PC from stack, two cycles.
// - Relative form addresses pointer plus signed offset, pointer kept.
module cir_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Instruction issue
  input wire logic op_valid,
  input wire cir_pkg::cir_op_t op_code,
  input wire logic [1:0] pointer_mode_code,
  input wire logic ptr_sel,
  input wire logic [5:0] rel_offset,
  input wire logic [7:0] literal,
  // Loading from the rest of the core
  input wire logic call_push,
  input wire logic [cir_pkg::PC_W-1:0] call_target,
  input wire logic [7:0] acc_load,
  input wire logic acc_load_en,
  input wire logic ptr_load_en,
  input wire logic [cir_pkg::PTR_W-1:0] ptr_load,
  input wire logic [7:0] status_in,
  input wire logic status_load_en,
  // Instruction state
  output logic busy,
  output logic [cir_pkg::PC_W-1:0] prog_counter,
  output logic [7:0] acc,
  output logic [7:0] status_flags,
  output logic [7:0] option_reg,
  output logic [7:0] interrupt_control_register,
  output logic [cir_pkg::PTR_W-1:0] indirect_pointer0,
  output logic [cir_pkg::PTR_W-1:0] indirect_pointer1,
  // Data memory write through the indirect window
  output logic mem_we,
  output logic [cir_pkg::PTR_W-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  // Reset control
  output logic soft_reset_req,
  output logic software_reset_flag_b
);
  cir_stack_if stk ();

  cir_stack u_stack (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .stk(stk)
  );

  typedef enum logic [0:0] {CIR_EXEC, CIR_RET2} cir_state_t;

  cir_state_t state;
  cir_state_t next_state;
  logic [cir_pkg::PTR_W-1:0] ptr [2];
  logic [cir_pkg::PTR_W-1:0] next_ptr [2];
  logic [cir_pkg::PC_W-1:0] next_pc;
  logic [7:0] next_acc;
  logic [7:0] next_status;
  logic [7:0] next_option;
  logic [7:0] next_interrupt_control_register;
  logic next_we;
  logic [cir_pkg::PTR_W-1:0] next_addr;
  logic [7:0] next_wdata;
  logic next_rst_req;
  logic next_ri_b;
  logic next_busy;
  logic [cir_pkg::PTR_W-1:0] cur;

  function automatic logic [cir_pkg::PTR_W-1:0] step(
    input logic [cir_pkg::PTR_W-1:0] p, input logic dec);
    // Natural 16-bit overflow gives the wrap at both ends
    step = dec ? p - 16'h0001 : p + 16'h0001;
  endfunction : step

  always_comb begin
    // Every register but state, busy, mem_we and soft_reset_req holds unless acc_load_en, status_load_en or a branch below loads it
    next_state = CIR_EXEC;
    next_ptr[0] = ptr[0];
    next_ptr[1] = ptr[1];
    next_pc = prog_counter;
    next_acc = acc_load_en ? acc_load : acc;
    next_status = status_load_en ? status_in : status_flags;
    next_option = option_reg;
    next_interrupt_control_register = interrupt_control_register;
    next_we = 1'b0;
    next_addr = mem_addr;
    next_wdata = mem_wdata;
    next_rst_req = 1'b0;
    next_ri_b = software_reset_flag_b;
    next_busy = 1'b0;
    cur = ptr[ptr_sel];
    stk.push = 1'b0;
    stk.pop = 1'b0;
    stk.push_data = prog_counter + 15'h0001;
    if (ptr_load_en) begin
      next_ptr[ptr_sel] = ptr_load;
    end
    if (state == CIR_RET2) begin
      // Pop only now: the registered top still holds the return address,
      // whereas popping in the first cycle would expose the entry below
      stk.pop = 1'b1;
      next_pc = stk.top;
    end else if (call_push) begin
      stk.push = 1'b1;
      next_pc = call_target;
    end else if (op_valid) begin
      next_pc = prog_counter + 15'h0001;
      case (op_code)
        cir_pkg::CIR_OP_NOP: begin
          next_pc = prog_counter + 15'h0001;
        end
        cir_pkg::CIR_OP_STORE_IND: begin
          // Status flags untouched on any pointer step
          next_we = 1'b1;
          next_wdata = acc;
          case (pointer_mode_code)
            cir_pkg::MODE_PRE_INC: begin
              next_addr = step(cur, 1'b0);
              next_ptr[ptr_sel] = next_addr;
            end
            cir_pkg::MODE_PRE_DEC: begin
              next_addr = step(cur, 1'b1);
              next_ptr[ptr_sel] = next_addr;
            end
            cir_pkg::MODE_POST_INC: begin
              next_addr = cur;
              next_ptr[ptr_sel] = step(cur, 1'b0);
            end
            default: begin
              next_addr = cur;
              next_ptr[ptr_sel] = step(cur, 1'b1);
            end
          endcase
        end
        cir_pkg::CIR_OP_STORE_REL: begin
          next_we = 1'b1;
          next_wdata = acc;
          next_addr = cur + {{10{rel_offset[5]}}, rel_offset};
        end
        cir_pkg::CIR_OP_OPTION: begin
          next_option = acc;
        end
        cir_pkg::CIR_OP_RESET: begin
          next_rst_req = 1'b1;
          next_ri_b = 1'b0;
        end
        cir_pkg::CIR_OP_RET_IRQ: begin
          next_interrupt_control_register[cir_pkg::GIE_BIT] = 1'b1;
          next_state = CIR_RET2;
          next_busy = 1'b1;
        end
        cir_pkg::CIR_OP_RETURN: begin
          next_state = CIR_RET2;
          next_busy = 1'b1;
        end
        cir_pkg::CIR_OP_RET_LIT: begin
          next_acc = literal;
          next_state = CIR_RET2;
          next_busy = 1'b1;
        end
        default: begin
          next_pc = prog_counter;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b || soft_reset_req) begin
      // Software reset flag survives its own reset so it can be read
      // The stack keeps its contents and depth across a soft reset
      state <= CIR_EXEC;
      ptr[0] <= cir_pkg::PTR_RESET;
      ptr[1] <= cir_pkg::PTR_RESET;
      prog_counter <= cir_pkg::PC_RESET;
      acc <= cir_pkg::ACC_RESET;
      status_flags <= cir_pkg::STATUS_RESET;
      option_reg <= cir_pkg::OPTION_RESET;
      interrupt_control_register <= cir_pkg::INTERRUPT_CONTROL_REGISTER_RESET;
      mem_we <= 1'b0;
      mem_addr <= cir_pkg::PTR_RESET;
      mem_wdata <= cir_pkg::WDATA_RESET;
      busy <= 1'b0;
      soft_reset_req <= 1'b0;
    end else begin
      state <= next_state;
      ptr[0] <= next_ptr[0];
      ptr[1] <= next_ptr[1];
      prog_counter <= next_pc;
      acc <= next_acc;
      status_flags <= next_status;
      option_reg <= next_option;
      interrupt_control_register <= next_interrupt_control_register;
      mem_we <= next_we;
      mem_addr <= next_addr;
      mem_wdata <= next_wdata;
      busy <= next_busy;
      soft_reset_req <= next_rst_req;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      software_reset_flag_b <= cir_pkg::SW_FLAG_RESET;
    end else begin
      software_reset_flag_b <= next_ri_b;
    end
  end

  assign indirect_pointer0 = ptr[0];
  assign indirect_pointer1 = ptr[1];
endmodule : cir_core

// File: verif/cir_core_props.sv
`timescale 1ns/10ps
module cir_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Core ports
  input wire logic op_valid,
  input wire cir_pkg::cir_op_t op_code,
  input wire logic [1:0] pointer_mode_code,
  input wire logic ptr_sel,
  input wire logic [7:0] literal,
  input wire logic call_push,
  input wire logic status_load_en,
  input wire logic busy,
  input wire logic [7:0] acc,
  input wire logic [7:0] status_flags,
  input wire logic [7:0] option_reg,
  input wire logic [7:0] interrupt_control_register,
  input wire logic [15:0] indirect_pointer0,
  input wire logic [15:0] indirect_pointer1,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic soft_reset_req,
  input wire logic software_reset_flag_b
);
  logic taken;
  logic [15:0] sel_p;
  logic [15:0] step_p;
  logic [15:0] addr_p;
  // A pending soft reset wipes the op, so it is not judged
  assign taken = op_valid && !busy && !call_push && !soft_reset_req;
  assign sel_p = ptr_sel ? indirect_pointer1 : indirect_pointer0;
  assign step_p = pointer_mode_code[0] ? sel_p - 16'h0001 : sel_p + 16'h0001;
  assign addr_p = pointer_mode_code[1] ? sel_p : step_p;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_op(cir_pkg::cir_op_t o);
    taken && op_code == o;
  endsequence
  sequence s_ret;
    busy ##1 !busy;
  endsequence
  store_addr_a: assert property (
    s_op(cir_pkg::CIR_OP_STORE_IND) |=> mem_we && mem_addr == $past(addr_p))
    else $error("store address wrong");
  ptr_wrap_a: assert property (
    s_op(cir_pkg::CIR_OP_STORE_IND) |=>
    ($past(ptr_sel) ? indirect_pointer1 : indirect_pointer0) == $past(step_p))
    else $error("pointer step wrong");
  flags_kept_a: assert property (
    !status_load_en && !soft_reset_req |=> $stable(status_flags))
    else $error("status flags moved");
  opt_load_a: assert property (
    s_op(cir_pkg::CIR_OP_OPTION) |=> option_reg == $past(acc))
    else $error("option load wrong");
  soft_reset_a: assert property (
    s_op(cir_pkg::CIR_OP_RESET) |=> soft_reset_req && !software_reset_flag_b
    ##1 !software_reset_flag_b && option_reg == cir_pkg::OPTION_RESET)
    else $error("soft reset wrong");
  ret_irq_a: assert property (
    s_op(cir_pkg::CIR_OP_RET_IRQ) |=>
    interrupt_control_register[cir_pkg::GIE_BIT] ##0 s_ret)
    else $error("irq return wrong");
  ret_two_a: assert property (
    s_op(cir_pkg::CIR_OP_RETURN) |=> s_ret)
    else $error("return length wrong");
  ret_lit_a: assert property (
    s_op(cir_pkg::CIR_OP_RET_LIT) |=> acc == $past(literal) ##0 s_ret)
    else $error("literal return wrong");
endmodule : cir_props
bind cir_core cir_props cir_chk (
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .op_valid(op_valid),
  .op_code(op_code),
  .pointer_mode_code(pointer_mode_code),
  .ptr_sel(ptr_sel),
  .literal(literal),
  .call_push(call_push),
  .status_load_en(status_load_en),
  .busy(busy),
  .acc(acc),
  .status_flags(status_flags),
  .option_reg(option_reg),
  .interrupt_control_register(interrupt_control_register),
  .indirect_pointer0(indirect_pointer0),
  .indirect_pointer1(indirect_pointer1),
  .mem_we(mem_we),
  .mem_addr(mem_addr),
  .soft_reset_req(soft_reset_req),
  .software_reset_flag_b(software_reset_flag_b)
);

// File: verif/cir_core_bench.sv
`timescale 1ns/10ps
module cir_core_bench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic op_valid = 1'b0;
  cir_pkg::cir_op_t op_code = cir_pkg::CIR_OP_NOP;
  logic [1:0] pointer_mode_code = 2'h0;
  logic ptr_sel = 1'b0;
  logic [5:0] rel_offset = 6'h00;
  logic [7:0] literal = 8'h00;
  logic call_push = 1'b0;
  logic [14:0] call_target = 15'h0000;
  logic [7:0] acc_load = 8'h00;
  logic acc_load_en = 1'b0;
  logic ptr_load_en = 1'b0;
  logic [15:0] ptr_load = 16'h0000;
  logic [7:0] status_in = 8'h00;
  logic status_load_en = 1'b0;
  logic busy, mem_we, soft_reset_req, software_reset_flag_b;
  logic [14:0] prog_counter, pc, ret;
  logic [7:0] acc, status_flags, option_reg, interrupt_control_register;
  logic [7:0] mem_wdata, a, st;
  logic [15:0] indirect_pointer0, indirect_pointer1, mem_addr, p, e;
  int errors = 0;
  int checks = 0;
  always #4 ref_clk = ~ref_clk;
  cir_core uut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .op_valid(op_valid),
    .op_code(op_code),
    .pointer_mode_code(pointer_mode_code),
    .ptr_sel(ptr_sel),
    .rel_offset(rel_offset),
    .literal(literal),
    .call_push(call_push),
    .call_target(call_target),
    .acc_load(acc_load),
    .acc_load_en(acc_load_en),
    .ptr_load_en(ptr_load_en),
    .ptr_load(ptr_load),
    .status_in(status_in),
    .status_load_en(status_load_en),
    .busy(busy),
    .prog_counter(prog_counter),
    .acc(acc),
    .status_flags(status_flags),
    .option_reg(option_reg),
    .interrupt_control_register(interrupt_control_register),
    .indirect_pointer0(indirect_pointer0),
    .indirect_pointer1(indirect_pointer1),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .soft_reset_req(soft_reset_req),
    .software_reset_flag_b(software_reset_flag_b)
  );
  function automatic logic [15:0] exp_step(logic [15:0] v, logic dec);
    exp_step = dec ? v - 16'h0001 : v + 16'h0001;
  endfunction : exp_step
  function automatic logic [15:0] exp_rel(logic [15:0] v, logic [5:0] k);
    exp_rel = v + 16'(signed'(k));
  endfunction : exp_rel
  function automatic logic [15:0] sel_ptr(logic s);
    sel_ptr = s ? indirect_pointer1 : indirect_pointer0;
  endfunction : sel_ptr
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task cmp(input string n, input logic [15:0] x, input logic [15:0] g);
    checks++;
    if (g !== x) begin
      errors++;
      $display("unexpected %0s: expected %h seen %h", n, x, g);
    end
  endtask : cmp
  task pre(input logic s, input logic [15:0] v, input logic [7:0] w);
    @(posedge ref_clk);
    ptr_sel <= s;
    ptr_load <= v;
    acc_load <= w;
    ptr_load_en <= 1'b1;
    acc_load_en <= 1'b1;
    @(posedge ref_clk);
    ptr_load_en <= 1'b0;
    acc_load_en <= 1'b0;
  endtask : pre
  task go(input cir_pkg::cir_op_t c, input logic [1:0] m, input logic [7:0] l);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= c;
    pointer_mode_code <= m;
    literal <= l;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
    pc = pc + 15'h0001;
  endtask : go
  initial begin
    void'($urandom(32'ha163));
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    st = 8'($urandom);
    status_in <= st;
    status_load_en <= 1'b1;
    @(posedge ref_clk);
    status_load_en <= 1'b0;
    pc = cir_pkg::PC_RESET;
    // Both wrap ends first, then random pointers
    for (int i = 0; i < 12; i++) begin
      p = i < 4 ? 16'hffff : i < 8 ? 16'h0000 : 16'($urandom);
      a = 8'($urandom);
      pre(i[2] ^ i[0], p, a);
      go(cir_pkg::CIR_OP_STORE_IND, i[1:0], 8'h00);
      e = exp_step(p, i[0]);
      cmp("mem_we", 16'h0001, 16'(mem_we));
      cmp("mem_addr", i[1] ? p : e, mem_addr);
      cmp("mem_wdata", 16'(a), 16'(mem_wdata));
      cmp("ptr", e, sel_ptr(i[2] ^ i[0]));
      cmp("status", 16'(st), 16'(status_flags));
    end
    $display("test store modes done");
    for (int i = 0; i < 3; i++) begin
      p = 16'($urandom);
      pre(i[0], p, 8'h5a);
      rel_offset <= i == 0 ? 6'h20 : i == 1 ? 6'h1f : 6'($urandom);
      go(cir_pkg::CIR_OP_STORE_REL, 2'h0, 8'h00);
      e = exp_rel(p, rel_offset);
      cmp("rel_addr", e, mem_addr);
      cmp("rel_ptr", p, sel_ptr(i[0]));
    end
    $display("test relative done");
    a = 8'($urandom);
    pre(1'b0, 16'h0000, a);
    go(cir_pkg::CIR_OP_OPTION, 2'h0, 8'h00);
    cmp("option", 16'(a), 16'(option_reg));
    go(cir_pkg::CIR_OP_NOP, 2'h0, 8'h00);
    cmp("pc", 16'(pc), 16'(prog_counter));
    cmp("acc", 16'(a), 16'(acc));
    $display("test option and nop done");
    for (int k = 0; k < 3; k++) begin
      ret = pc + 15'h0001;
      pc = 15'($urandom);
      @(posedge ref_clk);
      call_push <= 1'b1;
      call_target <= pc;
      @(posedge ref_clk);
      call_push <= 1'b0;
      a = 8'($urandom);
      go(cir_pkg::cir_op_t'(3'(k + 5)), 2'h0, a);
      cmp("busy", 16'h0001, 16'(busy));
      if (k == 0) begin
        cmp("gie", 16'h0001, 16'(interrupt_control_register[7]));
      end
      if (k == 2) cmp("acc", 16'(a), 16'(acc));
      repeat (cir_pkg::RET_CYCLES - 1) @(posedge ref_clk);
      #1;
      cmp("busy", 16'h0000, 16'(busy));
      cmp("ret_pc", 16'(ret), 16'(prog_counter));
      pc = ret;
    end
    $display("test returns done");
    go(cir_pkg::CIR_OP_RESET, 2'h0, 8'h00);
    cmp("req", 16'h0001, 16'(soft_reset_req));
    @(posedge ref_clk);
    #1;
    cmp("option", 16'(cir_pkg::OPTION_RESET), 16'(option_reg));
    cmp("pc", 16'(cir_pkg::PC_RESET), 16'(prog_counter));
    cmp("flag_b", 16'h0000, 16'(software_reset_flag_b));
    $display("test soft reset done");
    // Only the pin reset brings the software reset flag back
    @(posedge ref_clk);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    cmp("flag_b", 16'h0001, 16'(software_reset_flag_b));
    pc = cir_pkg::PC_RESET;
    go(cir_pkg::CIR_OP_NOP, 2'h0, 8'h00);
    cmp("pc", 16'(pc), 16'(prog_counter));
    $display("test pin reset done");
    tally_and_finish();
  end
endmodule : cir_core_bench
